/* File: hdl/ucc_pkg.sv */
// Summary of operation
// - channel state machines and their tick advance only while the clock-gate bit is 1; the noise filter compares ungated but counts gated RT ticks.
// - clearing an enable mid-frame lets that frame finish, then stops.
// - clearing transmit enable mid-frame discards the waiting buffer byte.
// - parity and base-clock settings are shared by transmit and receive.
// - base clock is gear or low-frequency clock, or the timer output.
// - with timer source the RT divider free-runs; first start may shorten.
// - stop length, parity, output and clock select locked while active.
// - RT count, noise select and receive stop length locked while active.
// - each locked field unlocks only when its enables and busies are 0.
// - low-power entry clears both enables and halts; other bits kept.
// - low-power entry leaves control register two unchanged.
// - transmitter sends one or two stop bits per transmit stop length.
// - receiver expects one or two stop bits per receive stop length.
// - with two receive stop bits only the second is framing-checked.
// - RT count select sets odd/even bit lengths; reserved codes give 16.
// - noise filter drops input pulses up to 0, 1, 2 or 3 RT periods.
// - control register two bits 7 and 6 read as zero.
// - a write to a locked bit leaves its old value.
package ucc_pkg;
   localparam logic [11:0] IDX_CR1  = 12'h01A;
   localparam logic [11:0] IDX_CR2  = 12'h01B;
   localparam logic [11:0] IDX_DIV  = 12'h01C;
   localparam logic [11:0] IDX_STAT = 12'h01D;
   localparam logic [11:0] IDX_BUF  = 12'h01E;
   localparam logic [11:0] IDX_GATE = 12'hF75;
   localparam int          GATE_BIT = 0;
   localparam logic [7:0]  CR1_RST  = 8'h00;
   localparam logic [7:0]  CR2_RST  = 8'h00;
   localparam logic [7:0]  DIV_RST  = 8'h00;
   localparam logic [7:0]  GATE_RST = 8'h00;
   localparam logic [4:0]  IR_PULSE = 5'h03;

   typedef struct packed {
      logic txe, rxe, stopbt, even, parity_add, irdasel, brg, zero;
   } ucc_cr1_t;
   typedef struct packed {
      logic [1:0] zero;
      logic [2:0] rtsel;
      logic [1:0] rxdnc;
      logic       stopbr;
   } ucc_cr2_t;
   typedef struct packed {
      logic perr, ferr, oerr, zero, rbsy, rbfl, tbsy, tbfl;
   } ucc_stat_t;
   typedef struct packed {
      logic        sel, en, wr;
      logic [13:0] addr;
      logic [31:0] wdata;
   } ucc_apb_req_t;

   typedef enum logic [5:0] {
      ST_IDLE  = 6'b000001,
      ST_START = 6'b000010,
      ST_DATA  = 6'b000100,
      ST_PAR   = 6'b001000,
      ST_STOP1 = 6'b010000,
      ST_STOP2 = 6'b100000
   } ucc_st_t;

   function automatic logic [13:0] ucc_baddr(input logic [11:0] idx);
      return {idx, 2'b00};
   endfunction

   // RT clocks per bit, odd = frame bits 1,3,5..
   function automatic logic [4:0] ucc_rt_len(input logic [2:0] sel,
                                              input logic odd);
      case (sel)
         3'h0: ucc_rt_len = 5'h10;
         3'h1: ucc_rt_len = odd ? 5'h10 : 5'h11;
         3'h2: ucc_rt_len = 5'h0F;
         3'h3: ucc_rt_len = odd ? 5'h0F : 5'h10;
         3'h4: ucc_rt_len = 5'h11;
         default: ucc_rt_len = 5'h10;
      endcase
   endfunction

   function automatic ucc_st_t ucc_next(input ucc_st_t st, input logic last,
                                        input logic parity_add,
                                        input logic two);
      case (st)
         ST_START: ucc_next = ST_DATA;
         ST_DATA:  ucc_next = !last ? ST_DATA
                                    : (parity_add ? ST_PAR : ST_STOP1);
         ST_PAR:   ucc_next = ST_STOP1;
         ST_STOP1: ucc_next = two ? ST_STOP2 : ST_IDLE;
         default:  ucc_next = ST_IDLE;
      endcase
   endfunction
endpackage

/* File: hdl/ucc_top.sv */
`timescale 1ns/10ps
module ucc_top #(
   parameter int unsigned PADDR_W = 14
) (
   // clock and reset
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   // apb slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [PADDR_W-1:0]    paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // base clock sources and power mode
   input  wire logic                  sys_clock_sel,
   input  wire logic                  low_freq_clock,
   input  wire logic                  divider_timer_output,
   input  wire logic                  low_power_entry,
   // serial pins
   input  wire logic                  serial_in_pin,
   output logic                       serial_out_pin
);
   import ucc_pkg::*;

   if (PADDR_W < 14) begin : g_chk
      $error("paddr too narrow for the register map");
   end

   ucc_apb_req_t req;
   ucc_cr1_t     cr1_q, cr1_d;
   ucc_cr2_t     cr2_q, cr2_d;
   ucc_stat_t    st;
   ucc_st_t      tx_q, rx_q;
   logic [7:0]   div_q, gate_q, cnt_q, txbuf_q, rxbuf_q, tsh_q, rsh_q;
   logic [4:0]   trt_q, rrt_q;
   logic [2:0]   tbit_q, rbit_q;
   logic [1:0]   nf_q;
   logic [2:0]   lf_s, tm_s, rx_s;
   logic         tbfl_q, rbfl_q, perr_q, ferr_q, oerr_q, tpar_q;
   logic         todd_q, rodd_q, filt_q, rt_q, pready_q, slverr_q;
   logic         dout_q;
   logic [31:0]  prdata_q;

   assign req = '{sel: psel, en: penable, wr: pwrite,
                  addr: paddr[13:0], wdata: pwdata};

   // bus decode
   wire        setup   = req.sel & ~req.en;
   wire        acc     = req.sel & req.en & pready_q;
   wire        acc_wr  = acc & req.wr;
   wire        acc_rd  = acc & ~req.wr;
   wire        hit_cr1 = req.addr == ucc_baddr(IDX_CR1);
   wire        hit_cr2 = req.addr == ucc_baddr(IDX_CR2);
   wire        hit_div = req.addr == ucc_baddr(IDX_DIV);
   wire        hit_st  = req.addr == ucc_baddr(IDX_STAT);
   wire        hit_buf = req.addr == ucc_baddr(IDX_BUF);
   wire        hit_gt  = req.addr == ucc_baddr(IDX_GATE);
   wire        mapped  = hit_cr1 | hit_cr2 | hit_div | hit_st | hit_buf
                         | hit_gt;
   wire        gate    = gate_q[GATE_BIT];
   wire        wr_ch   = acc_wr & gate;
   wire        wr_cr1  = wr_ch & hit_cr1;
   wire        wr_cr2  = wr_ch & hit_cr2 & ~low_power_entry;
   wire        wr_td   = wr_ch & hit_buf;
   wire        rd_rb   = acc_rd & hit_buf;
   wire        rd_st   = acc_rd & hit_st;
   wire        lp      = low_power_entry;
   wire [7:0]  wd      = req.wdata[7:0];

   wire        tx_busy = tx_q != ST_IDLE;
   wire        rx_busy = rx_q != ST_IDLE;
   wire        tx_free  = ~cr1_q.txe & ~tx_busy;
   wire        rx_free  = ~cr1_q.rxe & ~rx_busy;
   wire        all_free = tx_free & rx_free;
   ucc_cr1_t   w1;
   ucc_cr2_t   w2;
   assign w1 = wd;
   assign w2 = wd;

   assign cr1_d = '{txe: w1.txe, rxe: w1.rxe,
      stopbt:  tx_free  ? w1.stopbt  : cr1_q.stopbt,
      even:    all_free ? w1.even    : cr1_q.even,
      parity_add: all_free ? w1.parity_add : cr1_q.parity_add,
      irdasel: tx_free  ? w1.irdasel : cr1_q.irdasel,
      brg:     all_free ? w1.brg     : cr1_q.brg,
      zero:    1'b0};
   assign cr2_d = '{zero: 2'b00,
      rtsel:  all_free ? w2.rtsel  : cr2_q.rtsel,
      rxdnc:  rx_free  ? w2.rxdnc  : cr2_q.rxdnc,
      stopbr: rx_free  ? w2.stopbr : cr2_q.stopbr};

   assign st = '{perr: perr_q, ferr: ferr_q, oerr: oerr_q, zero: 1'b0,
                 rbsy: rx_busy, rbfl: rbfl_q, tbsy: tx_busy, tbfl: tbfl_q};

   wire [7:0] rd_val = hit_cr1 ? {cr1_q[7:1], 1'b0} :
                       hit_cr2 ? {2'b00, cr2_q[5:0]} :
                       hit_div ? div_q :
                       hit_st  ? st :
                       hit_buf ? rxbuf_q :
                       hit_gt  ? gate_q : 8'h00;

   // edge detect reads only the second and third stages
   wire lf_edge = lf_s[1] & ~lf_s[2];
   wire tm_edge = tm_s[1] & ~tm_s[2];
   wire base_tick = gate & (cr1_q.brg ? tm_edge :
                            (sys_clock_sel ? lf_edge : 1'b1));
   wire tx_start = gate & ~lp & (tx_q == ST_IDLE) & cr1_q.txe & tbfl_q;
   wire rx_start = gate & ~lp & (rx_q == ST_IDLE) & cr1_q.rxe & ~filt_q;
   // divider phase only aligned for synchronous sources
   wire div_sync = ~cr1_q.brg & ~tx_busy & ~rx_busy & (tx_start|rx_start);

   wire [4:0] tlen  = ucc_rt_len(cr2_q.rtsel, todd_q);
   wire [4:0] rlen  = ucc_rt_len(cr2_q.rtsel, rodd_q);
   wire       t_end = rt_q & (trt_q == tlen - 5'h01);
   wire       r_end = rt_q & (rrt_q == rlen - 5'h01);
   wire       r_mid = rt_q & (rrt_q == {1'b0, rlen[4:1]});
   wire       samp  = filt_q;
   wire       r_par = cr1_q.even ? ^rsh_q : ~^rsh_q;
   // parity generation, 1 even 0 odd
   wire       t_par = cr1_q.even ? ^txbuf_q : ~^txbuf_q;
   wire       tbit  = (tx_q == ST_START) ? 1'b0 :
                      (tx_q == ST_DATA)  ? tsh_q[0] :
                      (tx_q == ST_PAR)   ? tpar_q : 1'b1;
   wire       dout_d = cr1_q.irdasel ? (~tbit & (trt_q < IR_PULSE)) : tbit;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         slverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         slverr_q <= setup & ~mapped;
         if (setup) begin
            prdata_q <= {24'h00_0000, rd_val};
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cr1_q  <= CR1_RST;
         cr2_q  <= CR2_RST;
         div_q  <= DIV_RST;
         gate_q <= GATE_RST;
      end else begin
         if (acc_wr & hit_gt) begin
            gate_q <= wd;
         end
         if (wr_ch & hit_div) begin
            div_q <= wd;
         end
         if (wr_cr2) begin
            cr2_q <= cr2_d;
         end
         if (lp) begin
            cr1_q.txe <= 1'b0;
            cr1_q.rxe <= 1'b0;
         end else if (wr_cr1) begin
            cr1_q <= cr1_d;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lf_s <= 3'h0;
         tm_s <= 3'h0;
         rx_s <= 3'h7;
      end else begin
         lf_s <= {lf_s[1:0], low_freq_clock};
         tm_s <= {tm_s[1:0], divider_timer_output};
         rx_s <= {rx_s[1:0], serial_in_pin};
      end
   end

   // rt tick divider, free-running under timer source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= 8'h00;
         rt_q  <= 1'b0;
      end else begin
         rt_q <= 1'b0;
         if (div_sync) begin
            cnt_q <= 8'h00;
         end else if (base_tick) begin
            rt_q  <= cnt_q == div_q;
            cnt_q <= (cnt_q == div_q) ? 8'h00 : cnt_q + 8'h01;
         end
      end
   end

   // noise filter, counts rt periods of a changed level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_q <= 1'b1;
         nf_q   <= 2'h0;
      end else if (rx_s[2] == filt_q) begin
         nf_q <= 2'h0;
      end else if (nf_q >= cr2_q.rxdnc) begin
         filt_q <= rx_s[2];
         nf_q   <= 2'h0;
      end else if (rt_q) begin
         nf_q <= nf_q + 2'h1;
      end
   end

   // transmitter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_q    <= ST_IDLE;
         tbfl_q  <= 1'b0;
         txbuf_q <= 8'h00;
         tsh_q   <= 8'h00;
         tpar_q  <= 1'b0;
         trt_q   <= 5'h00;
         tbit_q  <= 3'h0;
         todd_q  <= 1'b1;
         dout_q  <= 1'b1;
      end else if (lp) begin
         tx_q   <= ST_IDLE;
         tbfl_q <= 1'b0;
         dout_q <= 1'b1;
      end else begin
         dout_q <= tx_busy ? dout_d : 1'b1;
         if (wr_td) begin
            txbuf_q <= wd;
         end
         // waiting byte dropped; a fresh write still sets
         if (wr_td) begin
            tbfl_q <= 1'b1;
         end else if (tx_start | (~cr1_q.txe & tx_busy)) begin
            tbfl_q <= 1'b0;
         end
         if (tx_start) begin
            tx_q   <= ST_START;
            tsh_q  <= txbuf_q;
            tpar_q <= t_par;
            trt_q  <= 5'h00;
            tbit_q <= 3'h0;
            todd_q <= 1'b1;
         end else if (gate & t_end) begin
            // stop count from transmit stop length
            tx_q   <= ucc_next(tx_q, tbit_q == 3'h7, cr1_q.parity_add,
                               cr1_q.stopbt);
            trt_q  <= 5'h00;
            todd_q <= ~todd_q;
            if (tx_q == ST_DATA) begin
               tsh_q  <= {1'b0, tsh_q[7:1]};
               tbit_q <= tbit_q + 3'h1;
            end
         end else if (gate & rt_q & tx_busy) begin
            trt_q <= trt_q + 5'h01;
         end
      end
   end

   // receiver
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_q    <= ST_IDLE;
         rsh_q   <= 8'h00;
         rxbuf_q <= 8'h00;
         rrt_q   <= 5'h00;
         rbit_q  <= 3'h0;
         rodd_q  <= 1'b1;
         rbfl_q  <= 1'b0;
         perr_q  <= 1'b0;
         ferr_q  <= 1'b0;
         oerr_q  <= 1'b0;
      end else if (lp) begin
         rx_q   <= ST_IDLE;
         rbfl_q <= 1'b0;
         perr_q <= 1'b0;
         ferr_q <= 1'b0;
         oerr_q <= 1'b0;
      end else begin
         // flag set wins over read clear
         if (rd_rb) begin
            rbfl_q <= 1'b0;
         end
         if (rd_st) begin
            perr_q <= 1'b0;
            ferr_q <= 1'b0;
            oerr_q <= 1'b0;
         end
         if (rx_start) begin
            rx_q   <= ST_START;
            rrt_q  <= 5'h00;
            rbit_q <= 3'h0;
            rodd_q <= 1'b1;
         end else if (gate & r_mid) begin
            rrt_q <= rrt_q + 5'h01;
            case (rx_q)
               ST_START: begin
                  if (samp) begin
                     rx_q <= ST_IDLE;
                  end
               end
               ST_DATA: rsh_q <= {samp, rsh_q[7:1]};
               ST_PAR: begin
                  if (samp != r_par) begin
                     perr_q <= 1'b1;
                  end
               end
               // first of two stop bits not checked
               ST_STOP1: begin
                  if (!cr2_q.stopbr & !samp) begin
                     ferr_q <= 1'b1;
                  end
               end
               ST_STOP2: begin
                  if (!samp) begin
                     ferr_q <= 1'b1;
                  end
               end
               default: rrt_q <= 5'h00;
            endcase
         end else if (gate & r_end) begin
            // stop count from receive stop length
            rx_q   <= ucc_next(rx_q, rbit_q == 3'h7, cr1_q.parity_add,
                               cr2_q.stopbr);
            rrt_q  <= 5'h00;
            rodd_q <= ~rodd_q;
            if (rx_q == ST_DATA) begin
               rbit_q <= rbit_q + 3'h1;
            end
            if ((rx_q == ST_STOP2) | (rx_q == ST_STOP1 & !cr2_q.stopbr))
            begin
               rxbuf_q <= rsh_q;
               rbfl_q  <= 1'b1;
               oerr_q  <= oerr_q | rbfl_q;
            end
         end else if (gate & rt_q & rx_busy) begin
            rrt_q <= rrt_q + 5'h01;
         end
      end
   end

   assign prdata         = prdata_q;
   assign pready         = pready_q;
   assign pslverr        = slverr_q;
   assign serial_out_pin = dout_q;

   property p_gate_hold;
      @(posedge pclk) disable iff (!presetn)
      (!gate && !lp) |=> $stable(tx_q) && $stable(rx_q);
   endproperty
   a_gate_hold: assert property (p_gate_hold)
      else $error("channel moved with clock gate off");

   property p_tx_finish;
      @(posedge pclk) disable iff (!presetn)
      (tx_q == ST_DATA && !cr1_q.txe && !lp && !t_end) |=> tx_q == ST_DATA;
   endproperty
   a_tx_finish: assert property (p_tx_finish)
      else $error("transmit frame cut short by disable");

   property p_discard;
      @(posedge pclk) disable iff (!presetn)
      (!cr1_q.txe && tx_busy && !wr_td) |=> !tbfl_q;
   endproperty
   a_discard: assert property (p_discard)
      else $error("waiting byte kept after disable");

   property p_cr1_lock;
      @(posedge pclk) disable iff (!presetn)
      (wr_cr1 && !all_free && !lp) |=> $stable(cr1_q.brg)
         && $stable(cr1_q.parity_add) && $stable(cr1_q.even);
   endproperty
   a_cr1_lock: assert property (p_cr1_lock)
      else $error("locked field of register one changed");

   property p_cr2_lock;
      @(posedge pclk) disable iff (!presetn)
      (wr_cr2 && !rx_free) |=> $stable(cr2_q.stopbr) && $stable(cr2_q.rxdnc);
   endproperty
   a_cr2_lock: assert property (p_cr2_lock)
      else $error("locked field of register two changed");

   property p_stop_unlock;
      @(posedge pclk) disable iff (!presetn)
      (wr_cr1 && tx_free && !lp) |=> cr1_q.stopbt == $past(w1.stopbt);
   endproperty
   a_stop_unlock: assert property (p_stop_unlock)
      else $error("free stop length write lost");

   property p_lowpower;
      @(posedge pclk) disable iff (!presetn)
      lp |=> !cr1_q.txe && !cr1_q.rxe && !tx_busy && !rx_busy
             && $stable(cr2_q);
   endproperty
   a_lowpower: assert property (p_lowpower)
      else $error("low-power entry did not halt channel");

   property p_two_stop;
      @(posedge pclk) disable iff (!presetn)
      (tx_q == ST_STOP2) |-> cr1_q.stopbt;
   endproperty
   a_two_stop: assert property (p_two_stop)
      else $error("second stop bit sent without two-stop mode");

   property p_rx_stop1;
      @(posedge pclk) disable iff (!presetn)
      (rx_q == ST_STOP1 && cr2_q.stopbr && r_mid && !rd_st && !lp)
         |=> ferr_q == $past(ferr_q);
   endproperty
   a_rx_stop1: assert property (p_rx_stop1)
      else $error("first of two stop bits was checked");

   property p_cr2_read;
      @(posedge pclk) disable iff (!presetn)
      (setup && hit_cr2) |=> prdata_q[7:6] == 2'b00;
   endproperty
   a_cr2_read: assert property (p_cr2_read)
      else $error("reserved bits of register two read nonzero");

   c_tx_frame: cover property (@(posedge pclk) disable iff (!presetn)
      tx_q == ST_STOP1 ##1 tx_q == ST_IDLE);
   c_rx_par: cover property (@(posedge pclk) disable iff (!presetn)
      rx_q == ST_PAR ##[1:400] rbfl_q);
   c_lp_busy: cover property (@(posedge pclk) disable iff (!presetn)
      lp && tx_busy);
endmodule

/* File: testbench/ucc_remote.sv */
`timescale 1ns/10ps
module ucc_remote (
   // clock shared with the bench
   input  wire logic pclk,
   // serial lines seen from the far device
   input  wire logic serial_out_pin,
   output logic      serial_in_pin
);
   // length of frame bit k; the start bit is odd bit one
   function automatic int blen(input int k, input int lo, input int le);
      return (k % 2 == 0) ? lo : le;
   endfunction

   initial serial_in_pin = 1'h1;

   // mid-bit sampling absorbs a shortened first start bit
   task automatic catch_frame(input int lo, input int le,
                              input logic parity_add,
                              output logic [7:0] d, output logic p,
                              output logic s1, output logic s2);
      logic [11:0] b;
      int          w;
      @(negedge serial_out_pin);
      repeat (lo / 2) @(posedge pclk);
      b[0] = serial_out_pin;
      for (int k = 1; k < 12; k++) begin
         w = blen(k - 1, lo, le);
         repeat (w - w / 2 + blen(k, lo, le) / 2) @(posedge pclk);
         b[k] = serial_out_pin;
      end
      d  = b[8:1];
      p  = b[9];
      s1 = parity_add ? b[10] : b[9];
      s2 = parity_add ? b[11] : b[10];
   endtask

   // drive bits lsb first, then back to the idle high level
   task automatic send_bits(input logic [11:0] v, input int n, input int len);
      for (int k = 0; k < n; k++) begin
         serial_in_pin <= v[k];
         repeat (len) @(posedge pclk);
      end
      serial_in_pin <= 1'h1;
   endtask
endmodule

/* File: testbench/uart_channel_config_control_bench.sv */
`timescale 1ns/10ps
module uart_channel_config_control_bench;
   import ucc_pkg::*;
   localparam int LIMIT = 30000;
   localparam logic [7:0] T_C1 [7] = '{8'h98, 8'h88, 8'h80, 8'h80, 8'h80,
                                       8'h80, 8'h82};
   localparam logic [7:0] T_C2 [7] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20,
                                       8'h00, 8'h00};
   localparam int T_LO [7] = '{16, 16, 15, 15, 17, 64, 128};
   localparam int T_LE [7] = '{16, 17, 15, 16, 17, 64, 128};
   logic        pclk = 1'h0;
   logic        presetn = 1'h0;
   logic        psel = 1'h0;
   logic        penable = 1'h0;
   logic        pwrite = 1'h0;
   logic [13:0] paddr = 14'h0000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sys_clock_sel = 1'h0;
   logic        low_freq_clock = 1'h0;
   logic        divider_timer_output = 1'h0;
   logic        low_power_entry = 1'h0;
   logic        serial_in_pin;
   logic        serial_out_pin;
   logic [2:0]  slow = 3'h0;
   logic [31:0] r;
   logic [7:0]  d;
   logic [7:0]  v;
   logic        e;
   logic        p;
   logic        s1;
   logic        s2;
   logic        x;
   int          errors = 0;
   int          n_checks = 0;
   int          cyc = 0;
   int          n;

   ucc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .sys_clock_sel(sys_clock_sel), .low_freq_clock(low_freq_clock),
      .divider_timer_output(divider_timer_output),
      .low_power_entry(low_power_entry), .serial_in_pin(serial_in_pin),
      .serial_out_pin(serial_out_pin));
   ucc_remote rem (.pclk(pclk), .serial_out_pin(serial_out_pin),
      .serial_in_pin(serial_in_pin));

   initial begin
      forever #50 pclk = ~pclk;
   end

   // slow sources: low-frequency tick every 4 cycles, timer every 8
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      slow <= slow + 3'h1;
      low_freq_clock <= slow[1];
      divider_timer_output <= slow[2];
      if (cyc == LIMIT) begin
         errors++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   // one idle cycle after each transfer keeps drives one per time step
   task automatic apb(input logic w, input logic [11:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd,
                      output logic err);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= {idx, 2'h0};
      pwdata <= {24'h000000, wd};
      @(posedge pclk);
      penable <= 1'h1;
      // only the bench timeout ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [11:0] idx, input logic [7:0] wd);
      apb(1'h1, idx, wd, r, e);
   endtask

   task automatic rc(input logic [11:0] idx, input logic [7:0] exp);
      apb(1'h0, idx, 8'h00, r, e);
      chk(r, {24'h000000, exp});
   endtask

   // wait until a status bit drops
   task automatic poll(input int b);
      do begin
         apb(1'h0, IDX_STAT, 8'h00, r, e);
      end while (r[b] !== 1'h0);
   endtask

   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'h1;
      @(posedge pclk);
      rc(IDX_CR1, 8'h00);
      rc(IDX_CR2, 8'h00);
      rc(IDX_DIV, 8'h00);
      rc(IDX_GATE, 8'h00);
      wr(IDX_CR1, 8'hFE);
      rc(IDX_CR1, 8'h00);
      wr(IDX_GATE, 8'h01);
      apb(1'h0, 12'h020, 8'h00, r, e);
      chk({r[31:1], e}, 32'h1);
      wr(IDX_DIV, 8'h5A);
      rc(IDX_DIV, 8'h5A);
      wr(IDX_DIV, 8'h00);
      wr(IDX_CR2, 8'hFF);
      rc(IDX_CR2, 8'h3F);
      wr(IDX_CR1, 8'hFF);
      rc(IDX_CR1, 8'hFE);
      wr(IDX_CR1, 8'hC0);
      rc(IDX_CR1, 8'hFE);
      wr(IDX_CR2, 8'h00);
      rc(IDX_CR2, 8'h3F);
      // the lock judges the enables held before the write
      wr(IDX_CR1, 8'h00);
      rc(IDX_CR1, 8'h3E);
      wr(IDX_CR1, 8'h00);
      wr(IDX_CR2, 8'h00);
      rc(IDX_CR2, 8'h00);
      for (int i = 0; i < 7; i++) begin
         poll(1);
         wr(IDX_CR1, 8'h00);
         sys_clock_sel <= (i == 5);
         wr(IDX_CR2, T_C2[i]);
         wr(IDX_CR1, T_C1[i]);
         v = 8'h35 + 8'(i);
         x = T_C1[i][3] ? (^v ^ !T_C1[i][4]) : 1'h1;
         fork
            wr(IDX_BUF, v);
            rem.catch_frame(T_LO[i], T_LE[i], T_C1[i][3], d, p, s1, s2);
         join
         chk({d, p, s1}, {22'h0, v, x, 1'h1});
      end
      // back to back: mid second stop slot shows stop or next start
      for (int s = 0; s < 2; s++) begin
         poll(1);
         wr(IDX_CR1, 8'h00);
         wr(IDX_CR1, s ? 8'hA0 : 8'h80);
         fork
            begin
               wr(IDX_BUF, 8'hC3);
               poll(0);
               wr(IDX_BUF, 8'h3C);
            end
            rem.catch_frame(16, 16, 1'h0, d, p, s1, s2);
         join
         chk(32'(s2), 32'(s));
      end
      poll(1);
      fork
         begin
            wr(IDX_BUF, 8'h96);
            poll(0);
            wr(IDX_BUF, 8'h69);
            wr(IDX_CR1, 8'h00);
         end
         rem.catch_frame(16, 16, 1'h0, d, p, s1, s2);
      join
      chk(32'(d), 32'h96);
      poll(1);
      rc(IDX_STAT, 8'h00);
      n = 0;
      repeat (400) begin
         @(posedge pclk);
         n += (serial_out_pin !== 1'h1);
      end
      chk(32'(n), 32'h0);
      wr(IDX_CR2, 8'h01);
      wr(IDX_CR1, 8'h58);
      rem.send_bits({1'h1, 1'h0, ^8'hA7, 8'hA7, 1'h0}, 12, 16);
      repeat (20) @(posedge pclk);
      rc(IDX_STAT, 8'h04);
      rc(IDX_BUF, 8'hA7);
      wr(IDX_CR1, 8'h18);
      wr(IDX_CR2, 8'h00);
      wr(IDX_CR1, 8'h58);
      rem.send_bits({1'h1, 1'h0, ~^8'h5E, 8'h5E, 1'h0}, 11, 16);
      repeat (20) @(posedge pclk);
      rc(IDX_STAT, 8'hC4);
      wr(IDX_CR1, 8'h18);
      wr(IDX_CR2, 8'h13);
      wr(IDX_CR1, 8'hD8);
      low_power_entry <= 1'h1;
      @(posedge pclk);
      low_power_entry <= 1'h0;
      @(posedge pclk);
      rc(IDX_CR1, 8'h18);
      rc(IDX_CR2, 8'h13);
      stop_test();
   end
endmodule
